/* File: rtl/nsr_consts.svh */
`ifndef NSR_CONSTS_SVH
`define NSR_CONSTS_SVH

// Flash command codes and the ID address byte
`define NSR_CMD_RESET     8'hFF
`define NSR_CMD_STATUS    8'h70
`define NSR_CMD_STATUS_MP 8'h71
`define NSR_CMD_ID        8'h90
`define NSR_CMD_ECC       8'h7A
`define NSR_ID_ADDR       8'h00

// Bytes returned per read sequence
`define NSR_ID_BYTES      3'h5
`define NSR_ECC_BYTES     3'h4
`define NSR_ONE_BYTE      3'h1

// Timing, in ns
`define NSR_CLK_NS        40
`define NSR_PHASE_NS      50
`define NSR_WB_NS         100

// Register offsets
`define NSR_REG_CTRL      4'h0
`define NSR_REG_STATE     4'h1
`define NSR_REG_RES0      4'h2
`define NSR_REG_RES4      4'h6
`define NSR_REG_DECODE    4'h7
`define NSR_REG_INTSTAT   4'h8
`define NSR_REG_INTMASK   4'h9

// Control register fields
`define NSR_CTRL_WPN      7
`define NSR_CTRL_WPN_RST  1'h0

// Status byte fields
`define NSR_STAT_FAIL     0
`define NSR_STAT_REWRITE  3
`define NSR_STAT_READY    6
`define NSR_STAT_WPN      7

// Correction report
`define NSR_ECC_UNCORR    4'hF

// Interrupt status bits
`define NSR_INT_DONE      0
`define NSR_INT_FAIL      1
`define NSR_INT_UNCORR    2
`define NSR_INT_REFUSED   3
`define NSR_INT_REWRITE   4
`define NSR_INT_W         5

`endif

/* File: rtl/nsr_pkg.sv */
package nsr_pkg;

  typedef enum logic [2:0] {
    OP_RESET,
    OP_STATUS,
    OP_STATUS_MP,
    OP_ID,
    OP_ECC,
    OP_REPOLL
  } nsr_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD_LO,
    ST_CMD_HI,
    ST_ADR_LO,
    ST_ADR_HI,
    ST_WAITB,
    ST_WAITR,
    ST_RD_LO,
    ST_RD_HI
  } nsr_state_t;

endpackage : nsr_pkg

/* File: rtl/nsr_ctrl.sv */
`timescale 1ns/100ps
`include "nsr_consts.svh"

module nsr_ctrl (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  output logic            irq,
  output logic            ceN,
  output logic            cleOut,
  output logic            aleOut,
  output logic            weN,
  output logic            readStrobeN,
  output logic            wpN,
  input  wire logic [7:0] ioIn,
  output logic      [7:0] ioOut,
  output logic            ioOe,
  input  wire logic       readyBusyOut
);

  localparam int PhaseCyc = (`NSR_PHASE_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS;
  localparam int WbCyc    = (`NSR_WB_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS;
  localparam logic [1:0] PhaseMax = 2'(PhaseCyc - 1);
  localparam logic [1:0] WbMax    = 2'(WbCyc - 1);

  nsr_pkg::nsr_state_t stateReg;
  nsr_pkg::nsr_state_t stateNext;
  nsr_pkg::nsr_op_t    opReg;
  nsr_pkg::nsr_op_t    opReq;
  nsr_pkg::nsr_op_t    opSel;
  logic [1:0]          phaseCnt_reg;
  logic [1:0]          waitCnt_reg;
  logic [2:0]          byteIdx_reg;
  logic [2:0]          nBytes;
  logic [7:0]          cmdByte;
  logic [7:0]          rdBuf_reg [0:4];
  logic                initPending_reg;
  logic                statusMode_reg;
  logic                wpCtl_reg;
  logic [`NSR_INT_W-1:0] intStat_reg;
  logic [`NSR_INT_W-1:0] intMask_reg;
  logic [`NSR_INT_W-1:0] events;
  logic                tick;
  logic                startReq;
  logic                startOk;
  logic                done;
  logic                eccUncorr;
  logic [7:0]          decode;

  assign tick     = (phaseCnt_reg == PhaseMax);
  assign opReq    = nsr_pkg::nsr_op_t'(regWdata[2:0]);
  // Opcode is still old on the start edge; the bus must carry the new command at once
  assign opSel    = (stateReg == nsr_pkg::ST_IDLE) ? opReq : opReg;
  assign startReq = regWr && (regAddr == `NSR_REG_CTRL) && (regWdata[2:0] <= 3'(nsr_pkg::OP_REPOLL));

  // Only reset and status go out while the part initialises or is busy
  always_comb begin
    startOk = startReq && (stateReg == nsr_pkg::ST_IDLE);
    if ((opReq == nsr_pkg::OP_ID || opReq == nsr_pkg::OP_ECC) && (initPending_reg || !readyBusyOut)) begin
      startOk = 1'b0;
    end
    if (opReq == nsr_pkg::OP_REPOLL && !statusMode_reg) begin
      startOk = 1'b0;
    end
  end

  always_comb begin
    case (opSel)
      nsr_pkg::OP_RESET:     cmdByte = `NSR_CMD_RESET;
      nsr_pkg::OP_STATUS:    cmdByte = `NSR_CMD_STATUS;
      nsr_pkg::OP_STATUS_MP: cmdByte = `NSR_CMD_STATUS_MP;
      nsr_pkg::OP_ID:        cmdByte = `NSR_CMD_ID;
      nsr_pkg::OP_ECC:       cmdByte = `NSR_CMD_ECC;
      default:               cmdByte = `NSR_CMD_STATUS;
    endcase
    case (opReg)
      nsr_pkg::OP_ID:  nBytes = `NSR_ID_BYTES;
      nsr_pkg::OP_ECC: nBytes = `NSR_ECC_BYTES;
      default:         nBytes = `NSR_ONE_BYTE;
    endcase
  end

  always_comb begin
    stateNext = stateReg;
    done      = 1'b0;
    case (stateReg)
      nsr_pkg::ST_IDLE: begin
        if (startOk) begin
          stateNext = (opReq == nsr_pkg::OP_REPOLL) ? nsr_pkg::ST_RD_LO : nsr_pkg::ST_CMD_LO;
        end
      end
      nsr_pkg::ST_CMD_LO: if (tick) stateNext = nsr_pkg::ST_CMD_HI;
      nsr_pkg::ST_CMD_HI: begin
        if (tick) begin
          if (opReg == nsr_pkg::OP_ID) begin
            stateNext = nsr_pkg::ST_ADR_LO;
          end else if (opReg == nsr_pkg::OP_RESET) begin
            stateNext = nsr_pkg::ST_WAITB;
          end else begin
            stateNext = nsr_pkg::ST_RD_LO;
          end
        end
      end
      nsr_pkg::ST_ADR_LO: if (tick) stateNext = nsr_pkg::ST_ADR_HI;
      nsr_pkg::ST_ADR_HI: if (tick) stateNext = nsr_pkg::ST_RD_LO;
      nsr_pkg::ST_WAITB:  if (waitCnt_reg == WbMax) stateNext = nsr_pkg::ST_WAITR;
      nsr_pkg::ST_WAITR: begin
        // Aborted copy pages are software's concern; we only wait for ready
        if (readyBusyOut) begin
          stateNext = nsr_pkg::ST_IDLE;
          done      = 1'b1;
        end
      end
      nsr_pkg::ST_RD_LO:  if (tick) stateNext = nsr_pkg::ST_RD_HI;
      nsr_pkg::ST_RD_HI: begin
        if (tick) begin
          if (byteIdx_reg == nBytes - 3'h1) begin
            stateNext = nsr_pkg::ST_IDLE;
            done      = 1'b1;
          end else begin
            stateNext = nsr_pkg::ST_RD_LO;
          end
        end
      end
      default: stateNext = nsr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg     <= nsr_pkg::ST_IDLE;
      phaseCnt_reg <= 2'h0;
      waitCnt_reg  <= 2'h0;
    end else begin
      stateReg     <= stateNext;
      phaseCnt_reg <= (tick || stateReg == nsr_pkg::ST_IDLE) ? 2'h0 : phaseCnt_reg + 2'h1;
      waitCnt_reg  <= (stateReg == nsr_pkg::ST_WAITB) ? waitCnt_reg + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opReg          <= nsr_pkg::OP_RESET;
      statusMode_reg <= 1'b0;
      byteIdx_reg    <= 3'h0;
    end else begin
      if (startOk) begin
        byteIdx_reg <= 3'h0;
        if (opReq != nsr_pkg::OP_REPOLL) begin
          opReg          <= opReq;
          statusMode_reg <= (opReq == nsr_pkg::OP_STATUS) || (opReq == nsr_pkg::OP_STATUS_MP);
        end
      end else if (stateReg == nsr_pkg::ST_RD_HI && tick) begin
        byteIdx_reg <= byteIdx_reg + 3'h1;
      end
    end
  end

  // Power-on: stay pending until the busy pin has been seen released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      initPending_reg <= 1'b1;
    end else if (stateReg == nsr_pkg::ST_IDLE && readyBusyOut) begin
      initPending_reg <= 1'b0;
    end
  end

  // Pins come straight from flops; next state decides them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ceN         <= 1'b1;
      cleOut      <= 1'b0;
      aleOut      <= 1'b0;
      weN         <= 1'b1;
      readStrobeN <= 1'b1;
      ioOut       <= 8'h00;
      ioOe        <= 1'b0;
    end else begin
      ceN         <= (stateNext == nsr_pkg::ST_IDLE);
      cleOut      <= (stateNext == nsr_pkg::ST_CMD_LO) || (stateNext == nsr_pkg::ST_CMD_HI);
      aleOut      <= (stateNext == nsr_pkg::ST_ADR_LO) || (stateNext == nsr_pkg::ST_ADR_HI);
      weN         <= !((stateNext == nsr_pkg::ST_CMD_LO) || (stateNext == nsr_pkg::ST_ADR_LO));
      readStrobeN <= (stateNext != nsr_pkg::ST_RD_LO);
      ioOe        <= (stateNext == nsr_pkg::ST_CMD_LO) || (stateNext == nsr_pkg::ST_CMD_HI) ||
                     (stateNext == nsr_pkg::ST_ADR_LO) || (stateNext == nsr_pkg::ST_ADR_HI);
      ioOut       <= (stateNext == nsr_pkg::ST_ADR_LO || stateNext == nsr_pkg::ST_ADR_HI) ?
                     `NSR_ID_ADDR : cmdByte;
    end
  end

  // Sample just before the strobe rises, data has had a full phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        rdBuf_reg[i] <= 8'h00;
      end
    end else if (stateReg == nsr_pkg::ST_RD_LO && tick) begin
      rdBuf_reg[byteIdx_reg] <= ioIn;
    end
  end

  always_comb begin
    eccUncorr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (rdBuf_reg[i][3:0] == `NSR_ECC_UNCORR) begin
        eccUncorr = 1'b1;
      end
    end
  end

  // Fail only counts once the status byte itself says ready
  assign decode = {4'h0,
                   rdBuf_reg[0][`NSR_STAT_FAIL] & rdBuf_reg[0][`NSR_STAT_READY],
                   rdBuf_reg[0][`NSR_STAT_REWRITE],
                   rdBuf_reg[0][`NSR_STAT_READY],
                   rdBuf_reg[0][`NSR_STAT_WPN]};

  always_comb begin
    events = '0;
    events[`NSR_INT_DONE]    = done;
    events[`NSR_INT_REFUSED] = startReq && !startOk;
    if (done && (opReg == nsr_pkg::OP_STATUS || opReg == nsr_pkg::OP_STATUS_MP)) begin
      events[`NSR_INT_FAIL]    = decode[3];
      events[`NSR_INT_REWRITE] = decode[2];
    end
    if (done && opReg == nsr_pkg::OP_ECC) begin
      events[`NSR_INT_UNCORR] = eccUncorr;
    end
  end

  // Read clears, but an event in the same cycle survives
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intStat_reg <= '0;
    end else if (regRd && regAddr == `NSR_REG_INTSTAT) begin
      intStat_reg <= events;
    end else begin
      intStat_reg <= intStat_reg | events;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intMask_reg <= '0;
      wpCtl_reg   <= `NSR_CTRL_WPN_RST;
    end else if (regWr && regAddr == `NSR_REG_INTMASK) begin
      intMask_reg <= regWdata[`NSR_INT_W-1:0];
    end else if (regWr && regAddr == `NSR_REG_CTRL) begin
      wpCtl_reg <= regWdata[`NSR_CTRL_WPN];
    end
  end

  assign irq = |(intStat_reg & intMask_reg);
  assign wpN = wpCtl_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr >= `NSR_REG_RES0 && regAddr <= `NSR_REG_RES4) begin
        regRdata <= rdBuf_reg[3'(regAddr - `NSR_REG_RES0)];
      end else begin
        case (regAddr)
          `NSR_REG_CTRL:    regRdata <= {wpCtl_reg, 4'h0, opReg};
          `NSR_REG_STATE:   regRdata <= {4'h0, stateReg != nsr_pkg::ST_IDLE, readyBusyOut,
                                         initPending_reg, statusMode_reg};
          `NSR_REG_DECODE:  regRdata <= decode;
          `NSR_REG_INTSTAT: regRdata <= {3'h0, intStat_reg};
          `NSR_REG_INTMASK: regRdata <= {3'h0, intMask_reg};
          default:          regRdata <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_status_strobe: assert property ($fell(cleOut) && (opReg == nsr_pkg::OP_STATUS) |-> ##[1:8] !readStrobeN)
    else $error("status command not followed by a read strobe");
  a_fail_ready: assert property (events[`NSR_INT_FAIL] |-> rdBuf_reg[0][`NSR_STAT_READY])
    else $error("fail reported while status showed busy");
  a_init_cmds: assert property (initPending_reg && !weN && cleOut |->
                                 ioOut inside {`NSR_CMD_RESET, `NSR_CMD_STATUS, `NSR_CMD_STATUS_MP})
    else $error("forbidden command during initialisation");
  a_id_address: assert property (!weN && aleOut |-> ioOut == `NSR_ID_ADDR && opReg == nsr_pkg::OP_ID)
    else $error("address cycle not a zero after identification command");
  a_repoll_mode: assert property ((stateReg == nsr_pkg::ST_IDLE) ##1 (stateReg == nsr_pkg::ST_RD_LO) |->
                                   $past(statusMode_reg))
    else $error("strobe without a command outside status mode");
  a_reset_wait: assert property ((stateReg == nsr_pkg::ST_WAITR) && !readyBusyOut |=>
                                  (stateReg == nsr_pkg::ST_WAITR) && !ceN)
    else $error("reset wait left before ready");

endmodule : nsr_ctrl

/* File: sim/nsr_flash_model.sv */
`timescale 1ns/100ps
module nsr_flash_model #(
  parameter logic [7:0] MAKER_CODE  = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3C, // Arbitrary value
  parameter int         INIT_NS     = 2000,
  parameter int         RESET_NS    = 400
) (
  input  wire logic       ceN,
  input  wire logic       cleOut,
  input  wire logic       aleOut,
  input  wire logic       weN,
  input  wire logic       readStrobeN,
  input  wire logic       wpN,
  input  wire logic [7:0] ioOut,
  input  wire logic       ioOe,
  input  wire logic       statFail,
  input  wire logic       statRewrite,
  input  wire logic       holdBusy,
  output logic      [7:0] ioIn,
  output logic            readyBusyOut
);
  logic [7:0] mode;
  logic [2:0] idx;
  logic       ready;
  logic [7:0] dataOut;
  logic       addrOk;
  // Open drain with pull-up, held low by internal busy
  assign readyBusyOut = ready & ~holdBusy;
  initial begin
    ready = 1'b0;
    mode  = 8'h00;
    idx   = 3'h0;
    addrOk = 1'b0;
    ioIn  = 8'hFF;
    #INIT_NS ready = 1'b1;
  end
  // ID bytes only follow a zero address cycle; bus taken only while driven
  always @(posedge weN) begin
    if (!ceN && cleOut && ioOe) begin
      mode   <= ioOut;
      idx    <= 3'h0;
      addrOk <= 1'b0;
      if (ioOut == 8'hFF) begin
        ready <= 1'b0;
        ready <= #RESET_NS 1'b1;
      end
    end else if (!ceN && aleOut && ioOe) begin
      addrOk <= (ioOut == 8'h00);
    end
  end
  always @* begin
    case (mode)
      8'h70:   dataOut = {wpN, readyBusyOut, readyBusyOut, 1'b0, statRewrite, 1'b0, 1'b0, statFail};
      8'h71:   dataOut = {wpN, readyBusyOut, readyBusyOut, 2'b00, statRewrite, statFail, statFail | statRewrite};
      8'h90:   dataOut = !addrOk ? 8'h00 : (idx == 3'h0) ? MAKER_CODE : (idx == 3'h1) ? DEVICE_CODE :
                         (idx == 3'h2) ? 8'h90 : (idx == 3'h3) ? 8'h15 : 8'hF6;
      8'h7A:   dataOut = {2'b00, idx[1:0], (idx == 3'h3) ? 4'hF : {2'b00, idx[1:0]}};
      default: dataOut = ~ioIn;
    endcase
  end
  always @(negedge readStrobeN) begin
    if (!ceN) ioIn = dataOut;
  end
  // Released bus shows the inverse, never stale data
  always @(posedge readStrobeN) begin
    ioIn = ~ioIn;
    idx  = idx + 3'h1;
  end
endmodule : nsr_flash_model

/* File: sim/test_nsr_ctrl.sv */
`timescale 1ns/100ps
module test_nsr_ctrl;
  logic       mclk, rst_n, regWr, regRd, irq, ceN, cleOut, aleOut, weN;
  logic       readStrobeN, wpN, ioOe, readyBusyOut, statFail, statRewrite, holdBusy;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, ioIn, ioOut, rd;
  int         failCount, nTests, cycles;
  nsr_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irq(irq), .ceN(ceN), .cleOut(cleOut), .aleOut(aleOut), .weN(weN),
    .readStrobeN(readStrobeN), .wpN(wpN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .readyBusyOut(readyBusyOut));
  nsr_flash_model #(.MAKER_CODE(8'hA5), .DEVICE_CODE(8'h3C)) u_flash (.ceN(ceN), .cleOut(cleOut),
    .aleOut(aleOut), .weN(weN), .readStrobeN(readStrobeN), .wpN(wpN), .ioOut(ioOut), .ioOe(ioOe),
    .statFail(statFail), .statRewrite(statRewrite),
    .holdBusy(holdBusy), .ioIn(ioIn), .readyBusyOut(readyBusyOut));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stopTest
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      stopTest();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    nTests++;
    if ((got & mask) !== (exp & mask)) begin
      failCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rd = regRdata;
  endtask : rdReg
  task automatic chkReg(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
    rdReg(a);
    chk(rd, exp, mask);
  endtask : chkReg
  // Start an op and poll the busy flag under a bound
  task automatic runOp(input logic wp, input logic [2:0] op);
    wrReg(4'h0, {wp, 4'h0, op});
    for (int i = 0; i < 500; i++) begin
      rdReg(4'h1);
      if (rd[3] === 1'b0) break;
    end
    // A poll that runs out is a hang, not a pass
    chk(rd, 8'h00, 8'h08);
  endtask : runOp
  task automatic tInit();
    chk({ceN, wpN, ioOe, 5'h0}, 8'h80, 8'hE0);
    chkReg(4'h1, 8'h02, 8'h02);
    wrReg(4'h0, 8'h03);
    chkReg(4'h8, 8'h08, 8'h08);
    chkReg(4'hA, 8'h00, 8'hFF);
    runOp(1'b0, 3'h0);
    chkReg(4'h1, 8'h00, 8'h02);
    chkReg(4'h8, 8'h01, 8'h0F);
  endtask : tInit
  task automatic tStatus();
    statFail    <= 1'b1;
    statRewrite <= 1'b1;
    wrReg(4'h9, 8'h02);
    runOp(1'b1, 3'h1);
    chkReg(4'h2, 8'hE9, 8'hFD);
    chkReg(4'h7, 8'h0F, 8'hFF);
    chk({7'h0, irq}, 8'h01, 8'hFF);
    chkReg(4'h8, 8'h13, 8'hFF);
    chk({7'h0, irq}, 8'h00, 8'hFF);
    statFail    <= 1'b0;
    statRewrite <= 1'b0;
    runOp(1'b1, 3'h5);
    chkReg(4'h2, 8'hE0, 8'hFD);
    statRewrite <= 1'b1;
    runOp(1'b1, 3'h2);
    chkReg(4'h2, 8'hE5, 8'hE7);
    chkReg(4'h8, 8'h03, 8'h1F);
  endtask : tStatus
  task automatic tBusy();
    holdBusy    <= 1'b1;
    statFail    <= 1'b1;
    statRewrite <= 1'b0;
    runOp(1'b0, 3'h1);
    chkReg(4'h2, 8'h01, 8'hFD);
    chkReg(4'h7, 8'h00, 8'h0F);
    wrReg(4'h0, 8'h03);
    chkReg(4'h8, 8'h08, 8'h0A);
    holdBusy <= 1'b0;
    statFail <= 1'b0;
  endtask : tBusy
  task automatic tReads();
    logic [7:0] idExp [5] = '{8'hA5, 8'h3C, 8'h90, 8'h15, 8'hF6};
    runOp(1'b1, 3'h3);
    for (int i = 0; i < 5; i++) chkReg(4'(i + 2), idExp[i], 8'hFF);
    wrReg(4'h0, 8'h85);
    chkReg(4'h8, 8'h08, 8'h08);
    runOp(1'b1, 3'h4);
    for (int i = 0; i < 4; i++) chkReg(4'(i + 2), {4'(i), (i == 3) ? 4'hF : 4'(i)}, 8'hFF);
    chkReg(4'h8, 8'h04, 8'h04);
  endtask : tReads
  initial begin
    rst_n = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    statFail = 1'b0;
    statRewrite = 1'b0;
    holdBusy = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    tInit();
    tStatus();
    tBusy();
    tReads();
    stopTest();
  end
endmodule : test_nsr_ctrl
